// file: sim/testbench.sv
// Self-checking bench for the CPU flag and register-pointing block.
// Assumes cpu_state_core answers one cycle after each request, one op per cycle.
`timescale 1ns/1ns
module testbench;
  // ==========================================
  // Clock, reset and stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cpu_state_pkg::alu_result_t alu = '0;
  cpu_state_pkg::reg_write_t reg_wr = '0;
  logic [7:0] rd_addr = 8'h00;
  logic [3:0] work_reg = 4'h0;
  logic work_access = 1'b0;
  logic stack_access = 1'b0;
  logic [7:0] flags, ptr_low, ptr_high, page_select, rd_data, phys_addr;
  logic [5:0] phys_page;
  logic addr_valid;
  int err_total = 0;
  int n_compared = 0;
  cpu_state_pkg::op_t carry_ops [8] = '{cpu_state_pkg::OP_ADD, cpu_state_pkg::OP_SUB,
    cpu_state_pkg::OP_CMP, cpu_state_pkg::OP_SHIFT, cpu_state_pkg::OP_SWAP,
    cpu_state_pkg::OP_ROT, cpu_state_pkg::OP_DECADJ, cpu_state_pkg::OP_MULDIV};
  cpu_state_pkg::op_t plain_ops [3] = '{cpu_state_pkg::OP_LOGIC, cpu_state_pkg::OP_INCDEC,
    cpu_state_pkg::OP_TEST};

  // 8 ns period for the 125 MHz core clock
  always #4 clk = ~clk;

  cpu_state_core cpu_state_core_inst (
    .clk(clk), .rst_n(rst_n), .alu(alu), .reg_wr(reg_wr), .rd_addr(rd_addr),
    .work_reg(work_reg), .work_access(work_access), .stack_access(stack_access),
    .flags(flags), .ptr_low(ptr_low), .ptr_high(ptr_high), .page_select(page_select),
    .rd_data(rd_data), .phys_addr(phys_addr), .phys_page(phys_page), .addr_valid(addr_valid)
  );

  // ==========================================
  // Access tasks and comparison
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One core op; cvh packs carry, overflow, half. Idle again after the taking edge
  task automatic run_op(input cpu_state_pkg::op_t op, input logic word,
                        input logic [15:0] res, input logic [2:0] cvh, input logic [7:0] opnd);
    @(posedge clk);
    alu <= '{op: op, word: word, result: res, carry: cvh[2], overflow: cvh[1],
             half: cvh[0], operand: opnd};
    @(posedge clk);
    alu <= '0;
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= '{write: 1'b1, addr: addr, data: data};
    @(posedge clk);
    reg_wr <= '0;
    #1;
  endtask

  // Read and translation request; answer is registered one edge later
  task automatic look(input logic [7:0] addr, input logic wa, input logic sa,
                      input logic [3:0] wreg);
    @(posedge clk);
    rd_addr <= addr;
    work_access <= wa;
    stack_access <= sa;
    work_reg <= wreg;
    @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d values, %0d mismatches", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs far fewer cycles
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("flags_reset", flags, 8'h00);
    check("ptr_low_reset", ptr_low, 8'h00);
    check("ptr_high_reset", ptr_high, 8'h00);
    // Software selects data space first and returns to it after selecting code
    run_op(cpu_state_pkg::OP_SEL_DATA, 1'b0, 16'h0000, 3'b000, 8'h00);
    check("dp_start", flags, 8'h01);
    // Word subtract then byte add whose low byte is zero
    run_op(cpu_state_pkg::OP_SUB, 1'b1, 16'h8000, 3'b010, 8'h00);
    check("sub_word", flags & 8'hfb, 8'h39);
    run_op(cpu_state_pkg::OP_ADD, 1'b0, 16'h0100, 3'b101, 8'h00);
    check("add_byte", flags, 8'hc5);
    // Word add: sign from bit 15, direction stays add, half carry kept
    run_op(cpu_state_pkg::OP_ADD, 1'b1, 16'h8000, 3'b000, 8'h00);
    check("add_word", flags, 8'h25);
    // Every carry-updating class, carry toggled each time
    for (int i = 0; i < 8; i++) begin
      run_op(carry_ops[i], 1'b0, 16'h0001, {i[0], 2'b00}, 8'h00);
      check("carry_class", {4'h0, flags[7:4]}, {4'h0, i[0], 3'b000});
    end
    // Classes that leave carry alone but move Z, S and V
    for (int i = 0; i < 3; i++) begin
      run_op(plain_ops[i], 1'b0, i[0] ? 16'h0080 : 16'h0000, {1'b0, ~i[0], 1'b0}, 8'h00);
      check("plain_class", {4'h0, flags[7:4]}, i[0] ? 8'h0a : 8'h0d);
    end
    // Reserved bit refuses a one from a register write
    wr_reg(cpu_state_pkg::ADDR_FLAGS, 8'hff);
    check("flags_bit1", flags, 8'hfd);
    wr_reg(cpu_state_pkg::ADDR_FLAGS, 8'h7d);
    run_op(cpu_state_pkg::OP_SET_C, 1'b0, 16'h0000, 3'b000, 8'h00);
    check("set_carry", flags, 8'hfd);
    run_op(cpu_state_pkg::OP_CLR_C, 1'b0, 16'h0000, 3'b111, 8'h00);
    check("clr_carry", flags, 8'h7d);
    run_op(cpu_state_pkg::OP_CPL_C, 1'b0, 16'h0000, 3'b000, 8'h00);
    check("cpl_carry", flags, 8'hfd);
    run_op(cpu_state_pkg::OP_SEL_CODE, 1'b0, 16'h0000, 3'b000, 8'h00);
    check("sel_code", flags, 8'hfc);
    run_op(cpu_state_pkg::OP_SEL_DATA, 1'b0, 16'h0000, 3'b000, 8'h00);
    check("sel_data", flags, 8'hfd);
    // Interrupt saves flags but not the page register
    run_op(cpu_state_pkg::OP_INT_ENTRY, 1'b0, 16'h0000, 3'b000, 8'h00);
    run_op(cpu_state_pkg::OP_SET_PAGE, 1'b0, 16'h0000, 3'b000, 8'h09);
    run_op(cpu_state_pkg::OP_CPL_C, 1'b0, 16'h0000, 3'b000, 8'h00);
    run_op(cpu_state_pkg::OP_INT_RETURN, 1'b0, 16'h0000, 3'b000, 8'h00);
    check("flags_restored", flags, 8'hfd);
    check("page_kept", page_select, 8'h24);
    look(cpu_state_pkg::ADDR_FLAGS, 1'b0, 1'b0, 4'h0);
    check("flags_read", rd_data, 8'hfd);
    // Twin mode: both pointers, both halves of the window
    run_op(cpu_state_pkg::OP_SET_TWIN_LOW, 1'b0, 16'h0000, 3'b000, 8'h05);
    check("twin_low", ptr_low, 8'h2c);
    check("twin_mode_high", ptr_high & 8'h04, 8'h04);
    run_op(cpu_state_pkg::OP_SET_TWIN_HIGH, 1'b0, 16'h0000, 3'b000, 8'h1f);
    check("twin_high", ptr_high, 8'hfc);
    check("low_kept", ptr_low, 8'h2c);
    look(8'h00, 1'b1, 1'b0, 4'h3);
    check("r3_twin", phys_addr, 8'h2b);
    look(8'h00, 1'b1, 1'b0, 4'h8);
    check("r8_twin", phys_addr, 8'hf8);
    look(8'h00, 1'b1, 1'b0, 4'hf);
    check("r15_twin", phys_addr, 8'hff);
    // Single mode with an odd block number
    run_op(cpu_state_pkg::OP_SET_SINGLE, 1'b0, 16'h0000, 3'b000, 8'h03);
    check("single_low", ptr_low, 8'h18);
    check("single_high", ptr_high, 8'hf8);
    look(8'h00, 1'b1, 1'b0, 4'h0);
    check("r0_single", phys_addr, 8'h10);
    look(8'h00, 1'b1, 1'b0, 4'hf);
    check("r15_single", phys_addr, 8'h1f);
    // Low pointer bits never hold a one
    wr_reg(cpu_state_pkg::ADDR_PTR_LOW, 8'hff);
    look(cpu_state_pkg::ADDR_PTR_LOW, 1'b0, 1'b0, 4'h0);
    check("ptr_low_read", rd_data, 8'hfc);
    wr_reg(cpu_state_pkg::ADDR_PTR_HIGH, 8'h03);
    look(cpu_state_pkg::ADDR_PTR_HIGH, 1'b0, 1'b0, 4'h0);
    check("ptr_high_read", rd_data, 8'h00);
    // Group D: refused direct, allowed through the stack pointer
    look(8'hd5, 1'b0, 1'b0, 4'h0);
    check("grp_d_direct", {7'h00, addr_valid}, 8'h01 ^ 8'h01);
    look(8'hd5, 1'b0, 1'b1, 4'h0);
    check("grp_d_stack", {7'h00, addr_valid}, 8'h01);
    check("grp_d_addr", phys_addr, 8'hd5);
    // Paged top group follows the page register
    run_op(cpu_state_pkg::OP_SET_PAGE, 1'b0, 16'h0000, 3'b000, 8'h05);
    check("page_set", page_select, 8'h14);
    look(8'hf2, 1'b0, 1'b0, 4'h0);
    check("page_steer", {2'b00, phys_page}, 8'h05);
    check("page_addr", phys_addr, 8'hf2);
    wr_reg(cpu_state_pkg::ADDR_PAGE, 8'hff);
    look(cpu_state_pkg::ADDR_PAGE, 1'b0, 1'b0, 4'h0);
    check("page_read", rd_data, 8'hfc);
    check("page_persist", {2'b00, phys_page}, 8'h05 ^ 8'h3a);
    look(8'h10, 1'b0, 1'b0, 4'h0);
    check("plain_read", rd_data, 8'h00);
    // A second reset mid-run clears the registers again
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("flags_rerst", flags, 8'h00);
    check("ptr_low_rerst", ptr_low, 8'h00);
    tally_and_finish();
  end
endmodule

// file: verilog/cpu_state_core.sv
// Contract
// - Carry set on carry out of bit 7 (byte) or bit 15 (word).
// - Carry updated only by arithmetic, shift, swap, rotate, adjust, multiply, divide.
// - Set, clear and complement carry touch no other flag.
// - Zero flag set when the affected result is zero.
// - Zero, sign, overflow also follow logical, complement, inc, dec, test.
// - Sign flag copies result bit 7 or bit 15.
// - Overflow set when signed result leaves the representable range.
// - Decimal flag records whether last arithmetic was add or subtract.
// - Half carry captures bit 3 carry or borrow on byte add/sub.
// - Flag bit 1 held at zero; software never writes one.
// - Select-data sets memory-space flag, select-code clears it.
// - Register file treated as 32 blocks of eight.
// - Single instruction clears mode bit; twin instructions set it, both pointers.
// - Single mode window starts at even block at or below given.
// - Twin mode: r0-r7 via low pointer, r8-r15 via high pointer.
// - Low pointer block field bits 7:3, written by single or twin-low.
// - High pointer block field loaded only by twin-high instruction; a register write to ADDR_PTR_HIGH also loads it.
// - Pointer bits 1:0 always read zero.
// - Group D reachable only via working or stack pointers.
// - Top group steered to one of 64 pages by persistent page register.
// - Interrupt entry does not save the page register.
// - Flag register resets to zero.
// - Flags pushed on interrupt and restored on return.
// - Page register holds 6-bit page in bits 7:2; bits 1:0 zero.
//
// Top of the CPU state block: flags, working pointers, page select and
// register address translation. Assumes the core issues one op per cycle.
`timescale 1ns/1ns
module cpu_state_core (
  input wire logic clk,
  input wire logic rst_n,
  input cpu_state_pkg::alu_result_t alu,
  input cpu_state_pkg::reg_write_t reg_wr,
  input wire logic [7:0] rd_addr,
  input wire logic [3:0] work_reg,
  input wire logic work_access,
  input wire logic stack_access,
  output logic [7:0] flags,
  output logic [7:0] ptr_low,
  output logic [7:0] ptr_high,
  output logic [7:0] page_select,
  output logic [7:0] rd_data,
  output logic [7:0] phys_addr,
  output logic [5:0] phys_page,
  output logic addr_valid
);
  // Default sampling for the checks at the bottom of this module
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Flag register and interrupt save stack
  logic [7:0] flag_q;
  logic [7:0] stack_top;
  logic flag_sw_write;
  assign flag_sw_write = reg_wr.write && reg_wr.addr == cpu_state_pkg::ADDR_FLAGS;
  flag_unit flags_i (
    .clk(clk),
    .rst_n(rst_n),
    .alu(alu),
    .sw_write(flag_sw_write),
    .sw_data(reg_wr.data),
    .stack_flags(stack_top),
    .flags(flag_q)
  );
  flag_stack stack_i (
    .clk(clk),
    .rst_n(rst_n),
    .push(alu.op == cpu_state_pkg::OP_INT_ENTRY),
    .pop(alu.op == cpu_state_pkg::OP_INT_RETURN),
    .push_data(flag_q),
    .top(stack_top)
  );
  assign flags = flag_q;
  // ==========================================
  // Pointer and page registers
  logic [7:0] next_ptr_low;
  logic [7:0] next_ptr_high;
  logic [7:0] next_page;
  // Instruction writes win over plain register writes in the same cycle
  always_comb begin
    next_ptr_low = ptr_low;
    next_ptr_high = ptr_high;
    next_page = page_select;
    if (reg_wr.write) begin
      if (reg_wr.addr == cpu_state_pkg::ADDR_PTR_LOW) begin
        next_ptr_low = reg_wr.data;
      end else if (reg_wr.addr == cpu_state_pkg::ADDR_PTR_HIGH) begin
        next_ptr_high = reg_wr.data;
      end else if (reg_wr.addr == cpu_state_pkg::ADDR_PAGE) begin
        next_page = reg_wr.data;
      end
    end
    case (alu.op)
      cpu_state_pkg::OP_SET_SINGLE: begin
        next_ptr_low = {alu.operand[4:0], 3'b000};
        next_ptr_high[cpu_state_pkg::PTR_MODE_BIT] = 1'b0;
      end
      cpu_state_pkg::OP_SET_TWIN_LOW: begin
        next_ptr_low = {alu.operand[4:0], 3'b100};
        next_ptr_high[cpu_state_pkg::PTR_MODE_BIT] = 1'b1;
      end
      cpu_state_pkg::OP_SET_TWIN_HIGH: begin
        next_ptr_high = {alu.operand[4:0], 3'b100};
        next_ptr_low[cpu_state_pkg::PTR_MODE_BIT] = 1'b1;
      end
      cpu_state_pkg::OP_SET_PAGE: begin
        next_page = {alu.operand[5:0], 2'b00};
      end
      default: ;
    endcase
    next_ptr_low[1:0] = 2'b00;
    next_ptr_high[1:0] = 2'b00;
    next_page[1:0] = 2'b00;
  end
  // Page register is untouched by interrupt entry: handlers save it themselves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_low <= cpu_state_pkg::PTR_RESET;
      ptr_high <= cpu_state_pkg::PTR_RESET;
      page_select <= cpu_state_pkg::PAGE_RESET;
    end else begin
      ptr_low <= next_ptr_low;
      ptr_high <= next_ptr_high;
      page_select <= next_page;
    end
  end
  // ==========================================
  // Address translation and read-back
  logic [7:0] next_phys;
  logic next_valid;
  logic [7:0] next_rd;
  logic [4:0] block;
  logic twin;
  always_comb begin
    twin = ptr_low[cpu_state_pkg::PTR_MODE_BIT];
    block = ptr_low[7:3];
    next_valid = 1'b1;
    if (work_access) begin
      // 32 blocks of eight registers
      if (twin) begin
        block = work_reg[3] ? ptr_high[7:3] : ptr_low[7:3];
        next_phys = {block, work_reg[2:0]};
      end else begin
        next_phys = {ptr_low[7:4], work_reg};
      end
    end else begin
      next_phys = rd_addr;
      // Direct full-address access may not reach group D
      if (!stack_access && rd_addr[7:4] == cpu_state_pkg::GROUP_D) begin
        next_valid = 1'b0;
      end
    end
    if (rd_addr == cpu_state_pkg::ADDR_FLAGS) begin
      next_rd = flag_q;
    end else if (rd_addr == cpu_state_pkg::ADDR_PTR_LOW) begin
      next_rd = ptr_low;
    end else if (rd_addr == cpu_state_pkg::ADDR_PTR_HIGH) begin
      next_rd = ptr_high;
    end else if (rd_addr == cpu_state_pkg::ADDR_PAGE) begin
      next_rd = page_select;
    end else begin
      next_rd = 8'h00;
    end
  end
  // Registered outputs; page travels with the address for group F
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phys_addr <= 8'h00;
      phys_page <= 6'h00;
      addr_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      phys_addr <= next_phys;
      phys_page <= page_select[7:2];
      addr_valid <= next_valid;
      rd_data <= next_rd;
    end
  end
  // ==========================================
  // Checks
  ptr_low_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    ptr_low[1:0] == 2'b00 && ptr_high[1:0] == 2'b00) else $error("pointer low bits set");
  single_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_SET_SINGLE |=> !ptr_low[2] && !ptr_high[2])
    else $error("single mode bit not cleared");
  twin_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_SET_TWIN_HIGH |=> ptr_high[7:3] == $past(alu.operand[4:0]))
    else $error("high pointer not loaded");
  even_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    work_access && !ptr_low[2] |=> phys_addr[7:4] == $past(ptr_low[7:4]))
    else $error("single window not even");
  group_d_a: assert property (@(posedge clk) disable iff (!rst_n)
    !work_access && !stack_access && rd_addr[7:4] == 4'hd |=> !addr_valid)
    else $error("group d reached directly");
  page_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_SET_PAGE && !reg_wr.write ##1
    alu.op != cpu_state_pkg::OP_SET_PAGE && !reg_wr.write |=> $stable(page_select))
    else $error("page select drifted");
  cover_twin: cover property (@(posedge clk) disable iff (!rst_n) work_access && ptr_low[2]);
  cover_int: cover property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_INT_ENTRY ##[1:20] alu.op == cpu_state_pkg::OP_INT_RETURN);

  // ==========================================
  // Decoded strobes, read only by the checks that follow
  logic op_single;
  logic op_twin_low;
  logic op_twin_high;
  logic op_page;
  logic op_entry;
  logic ptr_high_wr;
  assign op_single = alu.op == cpu_state_pkg::OP_SET_SINGLE;
  assign op_twin_low = alu.op == cpu_state_pkg::OP_SET_TWIN_LOW;
  assign op_twin_high = alu.op == cpu_state_pkg::OP_SET_TWIN_HIGH;
  assign op_page = alu.op == cpu_state_pkg::OP_SET_PAGE;
  assign op_entry = alu.op == cpu_state_pkg::OP_INT_ENTRY;
  assign ptr_high_wr = reg_wr.write && reg_wr.addr == cpu_state_pkg::ADDR_PTR_HIGH;

  // ==========================================
  // Pointer loading and mode checks

  single_load_a: assert property (
    op_single |=> ptr_low[7:3] == $past(alu.operand[4:0]))
    else $error("single pointer block wrong");

  twin_low_load_a: assert property (
    op_twin_low |=> ptr_low[7:3] == $past(alu.operand[4:0]) && ptr_low[2])
    else $error("twin low pointer wrong");

  twin_mode_a: assert property (
    op_twin_low || op_twin_high |=> ptr_low[2] && ptr_high[2])
    else $error("twin mode bit not set");

  high_kept_a: assert property (
    !op_twin_high && !ptr_high_wr |=> ptr_high[7:3] == $past(ptr_high[7:3]))
    else $error("high pointer block moved");

  // ==========================================
  // Translation checks

  twin_lower_a: assert property (
    work_access && ptr_low[2] && !work_reg[3]
    |=> phys_addr == {$past(ptr_low[7:3]), $past(work_reg[2:0])})
    else $error("twin lower half wrong");

  twin_upper_a: assert property (
    work_access && ptr_low[2] && work_reg[3]
    |=> phys_addr == {$past(ptr_high[7:3]), $past(work_reg[2:0])})
    else $error("twin upper half wrong");

  single_index_a: assert property (
    work_access && !ptr_low[2] |=> phys_addr[3:0] == $past(work_reg))
    else $error("single window index wrong");

  direct_addr_a: assert property (
    !work_access |=> phys_addr == $past(rd_addr))
    else $error("direct address changed");

  work_valid_a: assert property (
    work_access |=> addr_valid)
    else $error("pointer access refused");

  stack_valid_a: assert property (
    !work_access && stack_access |=> addr_valid)
    else $error("stack access refused");

  other_group_a: assert property (
    !work_access && rd_addr[7:4] != cpu_state_pkg::GROUP_D |=> addr_valid)
    else $error("plain group refused");

  // ==========================================
  // Page, interrupt and read-back checks

  page_bits_a: assert property (
    page_select[1:0] == 2'b00)
    else $error("page low bits set");

  page_load_a: assert property (
    op_page |=> page_select[7:2] == $past(alu.operand[5:0]))
    else $error("page number wrong");

  page_route_a: assert property (
    phys_page == $past(page_select[7:2]))
    else $error("page not steered");

  entry_page_a: assert property (
    op_entry && !reg_wr.write |=> $stable(page_select))
    else $error("page changed on entry");

  entry_flags_a: assert property (
    op_entry && !reg_wr.write |=> $stable(flags))
    else $error("flags changed on entry");

  high_read_a: assert property (
    rd_addr == cpu_state_pkg::ADDR_PTR_HIGH |=> rd_data[1:0] == 2'b00)
    else $error("high pointer reads low bits");

  page_read_a: assert property (
    rd_addr == cpu_state_pkg::ADDR_PAGE |=> rd_data == $past(page_select))
    else $error("page read wrong");

  flags_read_a: assert property (
    rd_addr == cpu_state_pkg::ADDR_FLAGS |=> rd_data == $past(flags))
    else $error("flag read wrong");

endmodule

// file: verilog/cpu_state_pkg.sv
// Package for the CPU flag and register-pointing block.
// Assumes a core sequencer that issues one operation per cycle.
package cpu_state_pkg;
  // ==========================================
  // Register file addresses
  localparam logic [7:0] ADDR_FLAGS = 8'he7;
  localparam logic [7:0] ADDR_PTR_LOW = 8'he8;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'he9;
  localparam logic [7:0] ADDR_PAGE = 8'hea;
  localparam logic [3:0] GROUP_D = 4'hd;
  localparam logic [3:0] GROUP_F = 4'hf;
  // ==========================================
  // Flag bit positions and reset values
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_DA = 3;
  localparam int FLAG_H = 2;
  localparam int FLAG_RSV = 1;
  localparam int FLAG_DP = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam int PTR_MODE_BIT = 2;
  localparam int BYTE_TOP = 7;
  localparam int WORD_TOP = 15;
  localparam int HALF_BIT = 3;
  // ==========================================
  // Operation classes issued by the core
  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_CMP = 5'h03,
    OP_SHIFT = 5'h04, OP_SWAP = 5'h05, OP_ROT = 5'h06, OP_DECADJ = 5'h07,
    OP_MULDIV = 5'h08, OP_LOGIC = 5'h09, OP_INCDEC = 5'h0a, OP_TEST = 5'h0b,
    OP_SET_C = 5'h0c, OP_CLR_C = 5'h0d, OP_CPL_C = 5'h0e, OP_SEL_DATA = 5'h0f,
    OP_SEL_CODE = 5'h10, OP_SET_SINGLE = 5'h11, OP_SET_TWIN_LOW = 5'h12,
    OP_SET_TWIN_HIGH = 5'h13, OP_SET_PAGE = 5'h14, OP_INT_ENTRY = 5'h15,
    OP_INT_RETURN = 5'h16
  } op_t;
  // Result of the datapath for one operation
  typedef struct packed {
    op_t op;
    logic word;
    logic [15:0] result;
    logic carry;
    logic overflow;
    logic half;
    logic [7:0] operand;
  } alu_result_t;
  // Register write from the register-file port
  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;
endpackage

// file: verilog/flag_stack.sv
// Small stack that saves the flags on interrupt entry.
// Assumes entry and return are balanced by the interrupt controller.
`timescale 1ns/1ns
module flag_stack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [7:0] push_data,
  output logic [7:0] top
);
  // Eight nesting levels, one entry each
  logic [7:0] mem [0:7];
  logic [2:0] depth;
  logic [2:0] next_depth;
  always_comb begin
    next_depth = depth;
    if (push) begin
      next_depth = depth + 3'h1;
    end else if (pop) begin
      next_depth = depth - 3'h1;
    end
  end
  // Storage; overflow past eight wraps, which software must avoid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      depth <= 3'h0;
    end else begin
      depth <= next_depth;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[depth] <= push_data;
    end
  end
  assign top = mem[depth - 3'h1];
endmodule

// file: verilog/flag_unit.sv
// Condition-flag register with its update logic.
// Assumes one alu_result_t per cycle from the core on the same clock.
`timescale 1ns/1ns
module flag_unit (
  input wire logic clk,
  input wire logic rst_n,
  input cpu_state_pkg::alu_result_t alu,
  input wire logic sw_write,
  input wire logic [7:0] sw_data,
  input wire logic [7:0] stack_flags,
  output logic [7:0] flags
);
  // ==========================================
  // Next-value logic
  logic [7:0] next_flags;
  logic top_bit;
  logic zero;
  logic arith;
  logic full;
  logic [7:0] restored;
  always_comb begin
    next_flags = flags;
    top_bit = alu.word ? alu.result[cpu_state_pkg::WORD_TOP]
                       : alu.result[cpu_state_pkg::BYTE_TOP];
    zero = alu.word ? (alu.result == 16'h0000) : (alu.result[7:0] == 8'h00);
    arith = alu.op inside {cpu_state_pkg::OP_ADD, cpu_state_pkg::OP_SUB,
                           cpu_state_pkg::OP_CMP, cpu_state_pkg::OP_SHIFT,
                           cpu_state_pkg::OP_SWAP, cpu_state_pkg::OP_ROT,
                           cpu_state_pkg::OP_DECADJ, cpu_state_pkg::OP_MULDIV};
    full = arith || alu.op inside {cpu_state_pkg::OP_LOGIC, cpu_state_pkg::OP_INCDEC,
                                   cpu_state_pkg::OP_TEST};
    restored = stack_flags;
    restored[cpu_state_pkg::FLAG_RSV] = 1'b0;
    if (sw_write) begin
      next_flags = sw_data;
    end else if (alu.op == cpu_state_pkg::OP_INT_RETURN) begin
      next_flags = restored;
    end else begin
      if (arith) begin
        next_flags[cpu_state_pkg::FLAG_C] = alu.carry;
      end
      if (full) begin
        next_flags[cpu_state_pkg::FLAG_Z] = zero;
        next_flags[cpu_state_pkg::FLAG_S] = top_bit;
        next_flags[cpu_state_pkg::FLAG_V] = alu.overflow;
      end
      // Any add/sub records direction; half carry only means something on bytes
      if (alu.op == cpu_state_pkg::OP_ADD || alu.op == cpu_state_pkg::OP_SUB) begin
        next_flags[cpu_state_pkg::FLAG_DA] = (alu.op == cpu_state_pkg::OP_SUB);
        if (!alu.word) begin
          next_flags[cpu_state_pkg::FLAG_H] = alu.half;
        end
      end
      case (alu.op)
        cpu_state_pkg::OP_SET_C: next_flags[cpu_state_pkg::FLAG_C] = 1'b1;
        cpu_state_pkg::OP_CLR_C: next_flags[cpu_state_pkg::FLAG_C] = 1'b0;
        cpu_state_pkg::OP_CPL_C: begin
          next_flags[cpu_state_pkg::FLAG_C] = ~flags[cpu_state_pkg::FLAG_C];
        end
        cpu_state_pkg::OP_SEL_DATA: next_flags[cpu_state_pkg::FLAG_DP] = 1'b1;
        cpu_state_pkg::OP_SEL_CODE: next_flags[cpu_state_pkg::FLAG_DP] = 1'b0;
        default: ;
      endcase
    end
    next_flags[cpu_state_pkg::FLAG_RSV] = 1'b0;
  end
  // Flag storage, cleared at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= cpu_state_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end
  // ==========================================
  // Checks
  flag_rsv_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    flags[cpu_state_pkg::FLAG_RSV] == 1'b0) else $error("reserved flag bit set");
  carry_cpl_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_CPL_C && !sw_write |=>
    flags[cpu_state_pkg::FLAG_C] != $past(flags[cpu_state_pkg::FLAG_C])
    && flags[6:0] == $past(flags[6:0])) else $error("complement carry wrong");
  zero_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_LOGIC && !sw_write && !alu.word |=>
    flags[cpu_state_pkg::FLAG_Z] == ($past(alu.result[7:0]) == 8'h00))
    else $error("zero flag wrong");
  sign_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_ADD && !sw_write && alu.word |=>
    flags[cpu_state_pkg::FLAG_S] == $past(alu.result[15])) else $error("sign flag wrong");
  carry_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_LOGIC && !sw_write |=>
    $stable(flags[cpu_state_pkg::FLAG_C])) else $error("carry changed by logic op");
  bcd_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    alu.op == cpu_state_pkg::OP_SUB && !alu.word && !sw_write |=>
    flags[cpu_state_pkg::FLAG_DA] && flags[cpu_state_pkg::FLAG_H] == $past(alu.half))
    else $error("bcd flags wrong");
  cover_cpl: cover property (@(posedge clk) disable iff (!rst_n) alu.op == cpu_state_pkg::OP_CPL_C);
  cover_dp: cover property (@(posedge clk) disable iff (!rst_n) flags[cpu_state_pkg::FLAG_DP]);
endmodule
